// ### aotpg_defines.vh
// offsets, fields and pattern words
// for the test pattern generator.
// assumes 15-bit register addresses.
`ifndef AOTPG_DEFINES_VH
`define AOTPG_DEFINES_VH

////////////////////////////////////////////////////////////////////////////
// register offsets
`define AOTPG_SOFT_RESET_CONFIG 15'h0000
`define AOTPG_DDC0_TEST_ENABLE 15'h0327
`define AOTPG_DDC1_TEST_ENABLE 15'h0347
`define AOTPG_DDC2_TEST_ENABLE 15'h0367
`define AOTPG_FOURTH_DOWNCONVERTER_TEST_ENABLE 15'h0387
`define AOTPG_CONVERTER_TEST_MODE 15'h0550
`define AOTPG_USER_PATTERN_BYTE0 15'h0551
`define AOTPG_USER_PATTERN_BYTE7 15'h0558
`define AOTPG_TRANSPORT_TEST_CONTROL 15'h0571
`define AOTPG_LINK_TEST_MODE 15'h0573
`define AOTPG_LINK_TEST_MODE_EXT 15'h0574

////////////////////////////////////////////////////////////////////////////
// fields and reset values
`define AOTPG_REG_RESET 8'h00
`define AOTPG_SOFT_RESET_CODE 8'h81
`define AOTPG_PN_LONG_RST_BIT 4
`define AOTPG_PN_SHORT_RST_BIT 5
`define AOTPG_USER_SINGLE_BIT 7
`define AOTPG_DDC_I_EN_BIT 0
`define AOTPG_DDC_Q_EN_BIT 2
`define AOTPG_SAMPLE_TEST_BIT 5

////////////////////////////////////////////////////////////////////////////
// test mode codes
`define AOTPG_MODE_OFF 4'h0
`define AOTPG_MODE_MIDSCALE 4'h1
`define AOTPG_MODE_POS_FS 4'h2
`define AOTPG_MODE_NEG_FS 4'h3
`define AOTPG_MODE_CHECKER 4'h4
`define AOTPG_MODE_PN_LONG 4'h5
`define AOTPG_MODE_PN_SHORT 4'h6
`define AOTPG_MODE_TOGGLE 4'h7
`define AOTPG_MODE_USER 4'h8
`define AOTPG_MODE_RAMP 4'hf

////////////////////////////////////////////////////////////////////////////
// pattern words, seeds, user word count and serial bit positions
`define AOTPG_WORD_MIDSCALE 14'h0000
`define AOTPG_WORD_POS_FS 14'h1fff
`define AOTPG_WORD_NEG_FS 14'h2000
`define AOTPG_WORD_CHECK_0 14'h1555
`define AOTPG_WORD_CHECK_1 14'h2aaa
`define AOTPG_WORD_ZERO 14'h0000
`define AOTPG_WORD_ONES 14'h3fff
`define AOTPG_PN_LONG_SEED 23'h00_3aff
`define AOTPG_PN_SHORT_SEED 23'h00_0092
`define AOTPG_USER_COUNT 3'h4
`define AOTPG_SPI_INSTR_BITS 5'h10
`define AOTPG_SPI_LAST_BIT 5'h17

`endif

// ### aotpg_top.v
// test pattern generator, serial register port,
// sample fifo and downconverter test mux.
// assumes samples and framer share clk; serial pins async.
`timescale 1ns/1ps
`include "aotpg_defines.vh"

////////////////////////////////////////////////////////////////////////////
// sample fifo
module aotpg_fifo #(
    parameter WIDTH = 28,
    parameter DEPTH = 16,
    parameter AW = 4
)(
    input wire clk,
    input wire resetn,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
    reg [AW:0] wr_ff;
    reg [AW:0] rd_ff;
    wire full;
    wire empty;
    wire push;
    wire pop;

    assign full = (wr_ff[AW-1:0] == rd_ff[AW-1:0]) && (wr_ff[AW] != rd_ff[AW]);
    assign empty = (wr_ff == rd_ff);
    assign in_ready = ~full;
    assign out_valid = ~empty;
    assign push = in_valid & ~full;
    assign pop = out_ready & ~empty;
    assign out_data = mem_ff[rd_ff[AW-1:0]];

    always @(posedge clk)
    begin
        if (push)
        begin
            mem_ff[wr_ff[AW-1:0]] <= in_data;
        end
    end

    always @(posedge clk)
    begin
        if (!resetn)
        begin
            wr_ff <= {(AW+1){1'b0}};
            rd_ff <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                wr_ff <= wr_ff + 1'b1;
            end
            if (pop)
            begin
                rd_ff <= rd_ff + 1'b1;
            end
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////
// What this block does
// - test mode replaces converter data with pattern
// - patterns ignore analog input, need clock
// - code 0 off, code 1 midscale zeros
// - codes 2/3 positive and negative full scale
// - code 4 checkerboard 0x1555 and 0x2aaa
// - code 5 long pseudorandom sequence, seed 0x3aff
// - code 6 short pseudorandom sequence, seed 0x092
// - code 7 toggles 0x0000 and 0x3fff
// - code 8 user patterns, repeat or single
// - code 15 ramp wrapping at 2^14
// - reset bits restart each pseudorandom generator
// - per downconverter test enables, bits 2/0
// - in-phase and quadrature both get the same pattern
// - fourth downconverter: only in-phase, bit 0
// - leaving link test needs soft reset 0x81
// - link test modes from two registers
// - transport sample test passes raw samples
// - link test bits 5:4 choose injection point
module aotpg_top #(
    parameter SAMPLE_W = 14,
    parameter DDC_W = 16,
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW = 4
)(
    input wire clk,
    input wire resetn,
    input wire spi_sclk,
    input wire spi_csb_n,
    input wire spi_sdio_in,
    output wire spi_sdio_out,
    output wire spi_sdio_oe_n,
    input wire adc_valid,
    output wire adc_ready,
    input wire [SAMPLE_W-1:0] adc_a,
    input wire [SAMPLE_W-1:0] adc_b,
    output wire link_valid,
    input wire link_ready,
    output wire [2*SAMPLE_W-1:0] link_data,
    input wire ddc_mode,
    input wire [4*DDC_W-1:0] ddc_i_in,
    input wire [4*DDC_W-1:0] ddc_q_in,
    output wire [4*DDC_W-1:0] ddc_i_out,
    output wire [4*DDC_W-1:0] ddc_q_out,
    output wire [3:0] link_test_sel,
    output wire [1:0] link_inject_point,
    output wire [7:0] link_test_ext,
    output wire transport_sample_test,
    output wire link_exit_pending
);
    ////////////////////////////////////////////////////////////////////////
    // functions
    // fourteen serial steps per sample, msb of state first out
    function [36:0] aotpg_pn14;
        input [22:0] s;
        input is_long;
        reg [22:0] t;
        reg [13:0] o;
        reg fb;
        integer k;
        begin
            t = s;
            o = 14'h0000;
            fb = 1'b0;
            for (k = 0; k < 14; k = k + 1)
            begin
                if (is_long)
                begin
                    o = {o[12:0], t[22]};
                    fb = t[22] ^ t[17];
                    t = {t[21:0], fb};
                end
                else
                begin
                    o = {o[12:0], t[8]};
                    fb = t[8] ^ t[4];
                    t = {14'h0000, t[7:0], fb};
                end
            end
            aotpg_pn14 = {o, t};
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // serial port pin synchronisers
    reg sclk_s1_ff;
    reg sclk_s2_ff;
    reg sclk_s3_ff;
    reg csb_s1_ff;
    reg csb_s2_ff;
    reg sdi_s1_ff;
    reg sdi_s2_ff;

    always @(posedge clk)
    begin
        if (!resetn)
        begin
            sclk_s1_ff <= 1'b0;
            sclk_s2_ff <= 1'b0;
            sclk_s3_ff <= 1'b0;
            csb_s1_ff <= 1'b1;
            csb_s2_ff <= 1'b1;
            sdi_s1_ff <= 1'b0;
            sdi_s2_ff <= 1'b0;
        end
        else
        begin
            sclk_s1_ff <= spi_sclk;
            sclk_s2_ff <= sclk_s1_ff;
            sclk_s3_ff <= sclk_s2_ff;
            csb_s1_ff <= spi_csb_n;
            csb_s2_ff <= csb_s1_ff;
            sdi_s1_ff <= spi_sdio_in;
            sdi_s2_ff <= sdi_s1_ff;
        end
    end

    wire sclk_rise = sclk_s2_ff & ~sclk_s3_ff;
    wire sclk_fall = ~sclk_s2_ff & sclk_s3_ff;

    ////////////////////////////////////////////////////////////////////////
    // serial port: 16-bit instruction then one data byte, msb first
    reg [23:0] sh_ff;
    reg [4:0] cnt_ff;
    reg rd_ff;
    reg [14:0] addr_ff;
    reg [7:0] dout_ff;
    reg sdo_ff;
    reg drive_ff;
    reg wr_stb_ff;
    reg [7:0] wr_data_ff;
    reg [7:0] rd_mux;
    wire [23:0] nxt_sh = {sh_ff[22:0], sdi_s2_ff};

    always @(posedge clk)
    begin
        if (!resetn || csb_s2_ff)
        begin
            sh_ff <= 24'h00_0000;
            cnt_ff <= 5'h00;
            rd_ff <= 1'b0;
            addr_ff <= 15'h0000;
            dout_ff <= 8'h00;
            sdo_ff <= 1'b0;
            drive_ff <= 1'b0;
            wr_stb_ff <= 1'b0;
            wr_data_ff <= 8'h00;
        end
        else
        begin
            wr_stb_ff <= 1'b0;
            if (sclk_rise && cnt_ff <= `AOTPG_SPI_LAST_BIT)
            begin
                sh_ff <= nxt_sh;
                cnt_ff <= cnt_ff + 5'h01;
                if (cnt_ff == `AOTPG_SPI_INSTR_BITS - 5'h01)
                begin
                    rd_ff <= nxt_sh[15];
                    addr_ff <= nxt_sh[14:0];
                end
                if (cnt_ff == `AOTPG_SPI_LAST_BIT && !rd_ff)
                begin
                    wr_stb_ff <= 1'b1;
                    wr_data_ff <= nxt_sh[7:0];
                end
            end
            // read data is captured once the address is known
            if (cnt_ff == `AOTPG_SPI_INSTR_BITS && !drive_ff && rd_ff)
            begin
                dout_ff <= rd_mux;
            end
            if (sclk_fall && rd_ff && cnt_ff >= `AOTPG_SPI_INSTR_BITS)
            begin
                drive_ff <= 1'b1;
                sdo_ff <= dout_ff[7];
                dout_ff <= {dout_ff[6:0], 1'b0};
            end
        end
    end

    assign spi_sdio_out = sdo_ff;
    assign spi_sdio_oe_n = ~drive_ff;

    ////////////////////////////////////////////////////////////////////////
    // register file
    reg [7:0] ddc_en_ff [0:3];
    reg [7:0] test_mode_ff;
    reg [7:0] user_ff [0:7];
    reg [7:0] transport_ff;
    reg [7:0] link_mode_ff;
    reg [7:0] link_ext_ff;
    reg exit_pend_ff;
    wire soft_rst = wr_stb_ff && addr_ff == `AOTPG_SOFT_RESET_CONFIG
        && wr_data_ff == `AOTPG_SOFT_RESET_CODE;
    wire user_hit = addr_ff >= `AOTPG_USER_PATTERN_BYTE0
        && addr_ff <= `AOTPG_USER_PATTERN_BYTE7;
    wire [2:0] user_idx = addr_ff[2:0] - 3'h1;
    integer i;

    always @(posedge clk)
    begin
        if (!resetn || soft_rst)
        begin
            for (i = 0; i < 4; i = i + 1)
            begin
                ddc_en_ff[i] <= `AOTPG_REG_RESET;
            end
            for (i = 0; i < 8; i = i + 1)
            begin
                user_ff[i] <= `AOTPG_REG_RESET;
            end
            test_mode_ff <= `AOTPG_REG_RESET;
            transport_ff <= `AOTPG_REG_RESET;
            link_mode_ff <= `AOTPG_REG_RESET;
            link_ext_ff <= `AOTPG_REG_RESET;
            exit_pend_ff <= 1'b0;
        end
        else if (wr_stb_ff)
        begin
            case (addr_ff)
                `AOTPG_DDC0_TEST_ENABLE: ddc_en_ff[0] <= wr_data_ff;
                `AOTPG_DDC1_TEST_ENABLE: ddc_en_ff[1] <= wr_data_ff;
                `AOTPG_DDC2_TEST_ENABLE: ddc_en_ff[2] <= wr_data_ff;
                `AOTPG_FOURTH_DOWNCONVERTER_TEST_ENABLE: ddc_en_ff[3] <= wr_data_ff;
                `AOTPG_CONVERTER_TEST_MODE: test_mode_ff <= wr_data_ff;
                `AOTPG_TRANSPORT_TEST_CONTROL: transport_ff <= wr_data_ff;
                `AOTPG_LINK_TEST_MODE:
                begin
                    link_mode_ff <= wr_data_ff;
                    // dropping back to normal leaves the link unsafe
                    if (link_mode_ff != 8'h00 && wr_data_ff == 8'h00)
                    begin
                        exit_pend_ff <= 1'b1;
                    end
                end
                `AOTPG_LINK_TEST_MODE_EXT: link_ext_ff <= wr_data_ff;
                default:
                begin
                    if (user_hit)
                    begin
                        user_ff[user_idx] <= wr_data_ff;
                    end
                end
            endcase
        end
    end

    always @*
    begin
        rd_mux = 8'h00;
        case (addr_ff)
            `AOTPG_DDC0_TEST_ENABLE: rd_mux = ddc_en_ff[0];
            `AOTPG_DDC1_TEST_ENABLE: rd_mux = ddc_en_ff[1];
            `AOTPG_DDC2_TEST_ENABLE: rd_mux = ddc_en_ff[2];
            `AOTPG_FOURTH_DOWNCONVERTER_TEST_ENABLE: rd_mux = ddc_en_ff[3];
            `AOTPG_CONVERTER_TEST_MODE: rd_mux = test_mode_ff;
            `AOTPG_TRANSPORT_TEST_CONTROL: rd_mux = transport_ff;
            `AOTPG_LINK_TEST_MODE: rd_mux = link_mode_ff;
            `AOTPG_LINK_TEST_MODE_EXT: rd_mux = link_ext_ff;
            default:
            begin
                if (user_hit)
                begin
                    rd_mux = user_ff[user_idx];
                end
            end
        endcase
    end

    assign link_test_sel = link_mode_ff[3:0];
    assign link_inject_point = link_mode_ff[5:4];
    assign link_test_ext = link_ext_ff;
    assign transport_sample_test = transport_ff[`AOTPG_SAMPLE_TEST_BIT];
    assign link_exit_pending = exit_pend_ff;

    ////////////////////////////////////////////////////////////////////////
    // pattern generators
    wire [3:0] mode = test_mode_ff[3:0];
    wire test_on = mode != `AOTPG_MODE_OFF;
    wire take = adc_valid & adc_ready;
    reg alt_ff;
    reg [SAMPLE_W-1:0] ramp_ff;
    reg [22:0] pnl_ff;
    reg [22:0] pns_ff;
    reg [2:0] uidx_ff;
    reg [SAMPLE_W-1:0] pat;
    wire [36:0] pnl_step = aotpg_pn14(pnl_ff, 1'b1);
    wire [36:0] pns_step = aotpg_pn14(pns_ff, 1'b0);
    wire [2:0] up = {uidx_ff[1:0], 1'b0};
    wire [15:0] user_word = {user_ff[up + 3'h1], user_ff[up]};

    always @*
    begin
        pat = `AOTPG_WORD_MIDSCALE;
        case (mode)
            `AOTPG_MODE_MIDSCALE: pat = `AOTPG_WORD_MIDSCALE;
            `AOTPG_MODE_POS_FS: pat = `AOTPG_WORD_POS_FS;
            `AOTPG_MODE_NEG_FS: pat = `AOTPG_WORD_NEG_FS;
            `AOTPG_MODE_CHECKER:
                pat = alt_ff ? `AOTPG_WORD_CHECK_1 : `AOTPG_WORD_CHECK_0;
            `AOTPG_MODE_PN_LONG: pat = pnl_step[36:23];
            `AOTPG_MODE_PN_SHORT: pat = pns_step[36:23];
            `AOTPG_MODE_TOGGLE:
                pat = alt_ff ? `AOTPG_WORD_ONES : `AOTPG_WORD_ZERO;
            `AOTPG_MODE_USER:
                pat = (uidx_ff == `AOTPG_USER_COUNT) ?
                    `AOTPG_WORD_ZERO : user_word[15:2];
            `AOTPG_MODE_RAMP: pat = ramp_ff;
            default: pat = `AOTPG_WORD_MIDSCALE;
        endcase
    end

    wire single = test_mode_ff[`AOTPG_USER_SINGLE_BIT];

    always @(posedge clk)
    begin
        if (!resetn || soft_rst)
        begin
            alt_ff <= 1'b0;
            ramp_ff <= {SAMPLE_W{1'b0}};
            pnl_ff <= `AOTPG_PN_LONG_SEED;
            pns_ff <= `AOTPG_PN_SHORT_SEED;
            uidx_ff <= 3'h0;
        end
        else
        begin
            // steps only on an accepted sample of the active mode
            if (take && (mode == `AOTPG_MODE_CHECKER
                || mode == `AOTPG_MODE_TOGGLE))
            begin
                alt_ff <= ~alt_ff;
            end
            if (take && mode == `AOTPG_MODE_RAMP)
            begin
                ramp_ff <= ramp_ff + 1'b1;
            end
            if (test_mode_ff[`AOTPG_PN_LONG_RST_BIT])
            begin
                pnl_ff <= `AOTPG_PN_LONG_SEED;
            end
            else if (take && mode == `AOTPG_MODE_PN_LONG)
            begin
                pnl_ff <= pnl_step[22:0];
            end
            if (test_mode_ff[`AOTPG_PN_SHORT_RST_BIT])
            begin
                pns_ff <= `AOTPG_PN_SHORT_SEED;
            end
            else if (take && mode == `AOTPG_MODE_PN_SHORT)
            begin
                pns_ff <= pns_step[22:0];
            end
            if (take && mode == `AOTPG_MODE_USER)
            begin
                if (uidx_ff == `AOTPG_USER_COUNT - 3'h1)
                begin
                    uidx_ff <= single ? `AOTPG_USER_COUNT : 3'h0;
                end
                else if (uidx_ff != `AOTPG_USER_COUNT)
                begin
                    uidx_ff <= uidx_ff + 3'h1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // converter path; analog side not selected
    wire use_pat = test_on & ~transport_sample_test;
    wire [SAMPLE_W-1:0] ch_a = use_pat ? pat : adc_a;
    wire [SAMPLE_W-1:0] ch_b = use_pat ? pat : adc_b;

    aotpg_fifo #(
        .WIDTH(2*SAMPLE_W),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .clk(clk),
        .resetn(resetn),
        .in_valid(adc_valid),
        .in_ready(adc_ready),
        .in_data({ch_a, ch_b}),
        .out_valid(link_valid),
        .out_ready(link_ready),
        .out_data(link_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // downconverter outputs; pattern in top bits
    reg [4*DDC_W-1:0] ddc_i_ff;
    reg [4*DDC_W-1:0] ddc_q_ff;
    wire [DDC_W-1:0] pat_w = {pat, {(DDC_W-SAMPLE_W){1'b0}}};
    integer d;

    always @(posedge clk)
    begin
        if (!resetn)
        begin
            ddc_i_ff <= {(4*DDC_W){1'b0}};
            ddc_q_ff <= {(4*DDC_W){1'b0}};
        end
        else
        begin
            ddc_i_ff <= ddc_i_in;
            ddc_q_ff <= ddc_q_in;
            for (d = 0; d < 4; d = d + 1)
            begin
                if (ddc_mode && test_on
                    && ddc_en_ff[d][`AOTPG_DDC_I_EN_BIT])
                begin
                    ddc_i_ff[d*DDC_W +: DDC_W] <= pat_w;
                end
                // fourth converter never carries a quadrature pattern
                if (ddc_mode && test_on && d != 3
                    && ddc_en_ff[d][`AOTPG_DDC_Q_EN_BIT])
                begin
                    ddc_q_ff[d*DDC_W +: DDC_W] <= pat_w;
                end
            end
        end
    end

    assign ddc_i_out = ddc_i_ff;
    assign ddc_q_out = ddc_q_ff;
endmodule

// ### aotpg_assertions.sv
// checker for the sample stream, link registers and fourth downconverter quadrature output
// bound onto aotpg_top; sees only its ports, one clock
`timescale 1ns/1ps
module aotpg_checker #(
    parameter SAMPLE_W = 14,
    parameter DDC_W = 16
)(
    input wire clk,
    input wire resetn,
    input wire spi_csb_n,
    input wire adc_valid,
    input wire adc_ready,
    input wire [SAMPLE_W-1:0] adc_a,
    input wire [SAMPLE_W-1:0] adc_b,
    input wire link_valid,
    input wire link_ready,
    input wire [2*SAMPLE_W-1:0] link_data,
    input wire [4*DDC_W-1:0] ddc_q_in,
    input wire [4*DDC_W-1:0] ddc_q_out,
    input wire [3:0] link_test_sel,
    input wire [1:0] link_inject_point,
    input wire [7:0] link_test_ext,
    input wire transport_sample_test,
    input wire link_exit_pending
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////
    valid_hold_a: assert property (
        link_valid && !link_ready |=> link_valid && $stable(link_data))
        else $error("link word not held");
    push_seen_a: assert property (
        adc_valid && adc_ready |=> link_valid)
        else $error("sample lost");
    no_phantom_a: assert property (
        !link_valid && !(adc_valid && adc_ready) |=> !link_valid)
        else $error("phantom link word");
    full_refuse_a: assert property (
        !adc_ready |-> link_valid)
        else $error("refused while empty");
    raw_pass_a: assert property (
        transport_sample_test && adc_valid && adc_ready && !link_valid
        |=> link_data == {$past(adc_a), $past(adc_b)})
        else $error("raw samples not passed");
    // link settings may only move while a serial frame is open
    regs_quiet_a: assert property (
        spi_csb_n [*8] |-> $stable({link_test_sel, link_inject_point,
        link_test_ext, transport_sample_test}))
        else $error("link settings moved");
    exit_flag_a: assert property (
        $rose(link_exit_pending) |-> link_test_sel == 4'h0
        && link_inject_point == 2'b00)
        else $error("exit flag in test");
    fourth_downconverter_q_a: assert property (
        $past(resetn) |-> ddc_q_out[4*DDC_W-1:3*DDC_W]
        == $past(ddc_q_in[4*DDC_W-1:3*DDC_W]))
        else $error("fourth_downconverter q altered");
endmodule

// ### aotpg_link_sink.sv
// framer model draining the sample stream
// assumes the design's clock; stall comes from the testbench
`timescale 1ns/1ps
module aotpg_link_sink (
    input wire clk,
    input wire resetn,
    input wire stall,
    input wire link_valid,
    input wire [27:0] link_data,
    output wire link_ready
);
    logic [27:0] q [$];
    // ready follows stall only, which moves just after an edge
    assign link_ready = !stall;
    always @(posedge clk)
    begin
        if (resetn && link_valid && link_ready)
            q.push_back(link_data);
    end
endmodule

// ### tb_adc_output_test_pattern_gen.sv
// testbench: serial register host, sample source, framer model
// assumes aotpg_top with default parameters and a 250 MHz clock
`timescale 1ns/1ps
`include "aotpg_defines.vh"
module tb_adc_output_test_pattern_gen;
    logic clk, resetn, spi_sclk, spi_csb_n, host_sdio, adc_valid;
    logic ddc_mode, stall;
    logic [13:0] adc_a, adc_b, w;
    logic [63:0] ddc_i_in, ddc_q_in;
    logic [7:0] r;
    logic [15:0] p;
    logic [27:0] x, y;
    integer bad_count, num_checks, i, j;
    logic [13:0] seq [0:8];
    logic [3:0] sm [0:2];
    wire spi_sdio_out, spi_sdio_oe_n, spi_sdio_in, adc_ready;
    wire link_valid, link_ready, transport_sample_test, link_exit_pending;
    wire [27:0] link_data;
    wire [63:0] ddc_i_out, ddc_q_out;
    wire [3:0] link_test_sel;
    wire [1:0] link_inject_point;
    wire [7:0] link_test_ext;
    // shared data pin: the device wins while its enable is low
    assign spi_sdio_in = spi_sdio_oe_n ? host_sdio : spi_sdio_out;
    aotpg_top i_dut (.*);
    aotpg_link_sink i_sink (.*);
    ////////////////////////////////////////////////////////////
    task chk(input logic [31:0] s, input logic [31:0] e);
        begin
            num_checks = num_checks + 1;
            if (s !== e)
            begin
                bad_count = bad_count + 1;
                $display("unexpected at %0t: seen %h expected %h",
                    $time, s, e);
            end
        end
    endtask
    task end_of_test;
        begin
            $display("checks %0d mismatches %0d", num_checks, bad_count);
            if (bad_count == 0 && num_checks > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    // one frame: rw, 15-bit address, 8 data bits, sclk phases of 5 clk
    task spi(input logic rw, input logic [14:0] a, input logic [7:0] d);
        logic [23:0] f;
        integer k;
        begin
            f = {rw, a, d};
            spi_csb_n = 1'b0;
            for (k = 23; k >= 0; k = k - 1)
            begin
                spi_sclk = 1'b0;
                host_sdio = f[k];
                repeat (5) @(posedge clk);
                #1;
                if (k < 8)
                    r[k] = spi_sdio_out;
                spi_sclk = 1'b1;
                repeat (5) @(posedge clk);
                #1;
            end
            spi_sclk = 1'b0;
            repeat (5) @(posedge clk);
            #1 spi_csb_n = 1'b1;
            repeat (8) @(posedge clk);
            #1;
        end
    endtask
    task wr(input logic [14:0] a, input logic [7:0] d);
        spi(1'b0, a, d);
    endtask
    task rdc(input logic [14:0] a, input logic [7:0] e);
        begin
            spi(1'b1, a, 8'h00);
            chk({24'h00_0000, r}, {24'h00_0000, e});
        end
    endtask
    task push(input logic [13:0] a, input logic [13:0] b);
        begin
            adc_a = a;
            adc_b = b;
            adc_valid = 1'b1;
            @(posedge clk);
            #1 adc_valid = 1'b0;
            @(posedge clk);
            #1;
        end
    endtask
    task smp(input logic [13:0] a, input logic [13:0] b,
        input logic [27:0] e);
        integer n;
        begin
            push(a, b);
            for (n = 0; n < 20 && i_sink.q.size() == 0; n = n + 1)
            begin
                @(posedge clk);
                #1;
            end
            chk({4'h0, i_sink.q.pop_front()}, {4'h0, e});
        end
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial
    begin
        #150000;
        bad_count = bad_count + 1;
        end_of_test;
    end
    initial
    begin
        bad_count = 0;
        num_checks = 0;
        resetn = 1'b0;
        spi_sclk = 1'b0;
        spi_csb_n = 1'b1;
        host_sdio = 1'b0;
        adc_valid = 1'b0;
        adc_a = 14'h0000;
        adc_b = 14'h0000;
        ddc_mode = 1'b0;
        stall = 1'b0;
        ddc_i_in = 64'h1111_2222_3333_4444;
        ddc_q_in = 64'h5555_6666_7777_8888;
        seq = '{14'h1555, 14'h2aaa, 14'h1555, 14'h3fff, 14'h0000,
            14'h3fff, 14'h125b, 14'h3c9a, 14'h2660};
        sm = '{4'h4, 4'h7, 4'h6};
        repeat (12) @(posedge clk);
        #1 resetn = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        rdc(`AOTPG_CONVERTER_TEST_MODE, 8'h00);
        rdc(`AOTPG_LINK_TEST_MODE, 8'h00);
        wr(15'h0100, 8'haa);
        rdc(15'h0100, 8'h00);
        smp(14'h1234, 14'h0abc, {14'h1234, 14'h0abc});
        $display("test registers done");
        for (i = 1; i < 4; i++)
        begin
            wr(`AOTPG_CONVERTER_TEST_MODE, i[7:0]);
            w = (i == 1) ? `AOTPG_WORD_MIDSCALE :
                (i == 2) ? `AOTPG_WORD_POS_FS : `AOTPG_WORD_NEG_FS;
            smp(14'h0abc, 14'h1234, {w, w});
        end
        for (i = 0; i < 3; i++)
        begin
            wr(`AOTPG_CONVERTER_TEST_MODE, {4'h0, sm[i]});
            for (j = 0; j < 3; j++)
                smp(14'h0abc, 14'h1234, {seq[3*i+j], seq[3*i+j]});
        end
        // seed held while reset bit set
        wr(`AOTPG_CONVERTER_TEST_MODE, 8'h26);
        wr(`AOTPG_CONVERTER_TEST_MODE, 8'h06);
        smp(14'h0abc, 14'h1234, {14'h125b, 14'h125b});
        $display("test patterns done");
        // ramp starts from the reset value 0, but only the step is checked
        wr(`AOTPG_CONVERTER_TEST_MODE, 8'h0f);
        for (i = 0; i < 3; i++)
            push(14'h0abc, 14'h1234);
        repeat (4) @(posedge clk);
        #1 x = i_sink.q.pop_front();
        for (i = 0; i < 2; i++)
        begin
            y = i_sink.q.pop_front();
            chk({18'h0_0000, y[13:0]}, {18'h0_0000, x[13:0] + 14'h0001});
            x = y;
        end
        for (i = 0; i < 4; i++)
        begin
            p = {8'hc0 | i[7:0], 8'h5a + i[7:0]};
            wr(`AOTPG_USER_PATTERN_BYTE0 + 2 * i[14:0], p[7:0]);
            wr(`AOTPG_USER_PATTERN_BYTE0 + 2 * i[14:0] + 15'h0001, p[15:8]);
        end
        wr(`AOTPG_CONVERTER_TEST_MODE, 8'h88);
        for (i = 0; i < 5; i++)
        begin
            p = {8'hc0 | i[7:0], 8'h5a + i[7:0]};
            w = (i < 4) ? p[15:2] : 14'h0000;
            smp(14'h0abc, 14'h1234, {w, w});
        end
        wr(`AOTPG_TRANSPORT_TEST_CONTROL, 8'h20);
        smp(14'h0321, 14'h2345, {14'h0321, 14'h2345});
        wr(`AOTPG_TRANSPORT_TEST_CONTROL, 8'h00);
        $display("test ramp user done");
        ddc_mode = 1'b1;
        wr(`AOTPG_CONVERTER_TEST_MODE, 8'h02);
        wr(`AOTPG_DDC0_TEST_ENABLE, 8'h05);
        wr(`AOTPG_FOURTH_DOWNCONVERTER_TEST_ENABLE, 8'h05);
        chk(ddc_i_out[15:0], {`AOTPG_WORD_POS_FS, 2'b00});
        chk(ddc_q_out[15:0], {`AOTPG_WORD_POS_FS, 2'b00});
        chk(ddc_i_out[31:16], ddc_i_in[31:16]);
        chk(ddc_i_out[63:48], {`AOTPG_WORD_POS_FS, 2'b00});
        chk(ddc_q_out[63:48], ddc_q_in[63:48]);
        $display("test ddc done");
        for (i = 0; i < 3; i++)
        begin
            wr(`AOTPG_LINK_TEST_MODE, {2'b00, i[1:0], 4'h1 + i[3:0]});
            chk(link_inject_point, i[1:0]);
            chk(link_test_sel, 4'h1 + i[3:0]);
        end
        wr(`AOTPG_LINK_TEST_MODE_EXT, 8'h5a);
        chk(link_test_ext, 8'h5a);
        wr(`AOTPG_LINK_TEST_MODE, 8'h00);
        chk(link_exit_pending, 1'b1);
        wr(`AOTPG_SOFT_RESET_CONFIG, `AOTPG_SOFT_RESET_CODE);
        chk(link_exit_pending, 1'b0);
        rdc(`AOTPG_SOFT_RESET_CONFIG, 8'h00);
        rdc(`AOTPG_LINK_TEST_MODE_EXT, 8'h00);
        $display("test link done");
        // 17 samples into a stalled framer
        stall = 1'b1;
        adc_valid = 1'b1;
        for (i = 0; i < 17; i++)
        begin
            adc_a = i[13:0];
            adc_b = ~i[13:0];
            @(posedge clk);
            #1;
        end
        adc_valid = 1'b0;
        chk(adc_ready, 1'b0);
        stall = 1'b0;
        repeat (20) @(posedge clk);
        #1;
        chk(i_sink.q.size(), 16);
        chk(i_sink.q[15], {14'h000f, ~14'h000f});
        $display("test fifo done");
        end_of_test;
    end
endmodule
bind aotpg_top aotpg_checker #(.SAMPLE_W(SAMPLE_W), .DDC_W(DDC_W)) i_chk (.*);
